// File: hdl/tmc_channel_counter.sv
/*
 Channel two counter: 16-bit up/down counter, status flags, two general
 compare/capture registers, behind an Avalon-MM slave with waitrequest.
 Assumes all event inputs are synchronous one-cycle pulses or levels on clock.
*/
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module tmc_channel_counter
	import tmc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic count_tick,
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic cascade_overflow,
	input wire logic cascade_underflow,
	input wire logic capture_a,
	input wire logic capture_b,
	input wire logic xfer_done_a,
	input wire logic xfer_done_b,
	input wire logic xfer_disable_select,
	input wire logic xfer_count_nonzero,
	output logic [15:0] count_value,
	output logic count_up_dir
);
	tmc_state_t st_reg;
	tmc_state_t st_next;
	logic up_evt;
	logic down_evt;
	logic [15:0] idx;
	logic wr_done;
	logic rd_done;
	logic xfer_clear;

	assign idx = address[ADDR_W-1:2];
	// the access completes on the edge where waitrequest is seen low
	assign wr_done = write && !st_reg.wait_hi;
	assign rd_done = read && !st_reg.wait_hi;
	assign xfer_clear = !xfer_disable_select && xfer_count_nonzero;

	always_comb
	begin
		up_evt = 1'b0;
		down_evt = 1'b0;
		if (st_reg.en)
		begin
			case (st_reg.mode)
				TMC_MODE_PHASE:
				begin
					// four-edge quadrature; a simultaneous edge on both phases is dropped as invalid
					if ((phase_a != st_reg.ph_a) && (phase_b == st_reg.ph_b))
					begin
						up_evt = (phase_a != phase_b);
						down_evt = (phase_a == phase_b);
					end
					else if ((phase_b != st_reg.ph_b) && (phase_a == st_reg.ph_a))
					begin
						up_evt = (phase_a == phase_b);
						down_evt = (phase_a != phase_b);
					end
				end
				TMC_MODE_CASCADE:
				begin
					up_evt = cascade_overflow && !cascade_underflow;
					down_evt = cascade_underflow && !cascade_overflow;
				end
				TMC_MODE_NORMAL:
				begin
					up_evt = count_tick;
				end
				default:
				begin
					up_evt = 1'b0;
				end
			endcase
		end
	end

	always_comb
	begin
		logic [15:0] cnt_new;
		cnt_new = st_reg.cnt;
		st_next = st_reg;
		st_next.ph_a = phase_a;
		st_next.ph_b = phase_b;
		st_next.wait_hi = !((read || write) && st_reg.wait_hi);
		if ((read || write) && st_reg.wait_hi)
		begin
			st_next.rdata = 32'h00000000;
			case (idx)
				IDX_CTRL: st_next.rdata = {27'h0000000, st_reg.capb, st_reg.capa, st_reg.mode, st_reg.en};
				IDX_STATUS: st_next.rdata = {24'h000000, st_reg.dir, 1'b1, st_reg.udf, st_reg.ovf, 2'b00,
					st_reg.flag_b, st_reg.flag_a};
				IDX_COUNT: st_next.rdata = {16'h0000, st_reg.cnt};
				IDX_GRA: st_next.rdata = {16'h0000, st_reg.gra};
				IDX_GRB: st_next.rdata = {16'h0000, st_reg.grb};
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		// reading a flag as 1 arms it for clearing
		if (rd_done && idx == IDX_STATUS)
		begin
			st_next.arm_a = st_reg.flag_a;
			st_next.arm_b = st_reg.flag_b;
			st_next.arm_ovf = st_reg.ovf;
			st_next.arm_udf = st_reg.udf;
		end
		if (wr_done)
		begin
			case (idx)
				IDX_CTRL:
				begin
					if (byteenable[0])
					begin
						st_next.en = writedata[CTRL_EN_BIT];
						st_next.mode = tmc_mode_t'(writedata[CTRL_MODE_LSB +: 2]);
						st_next.capa = writedata[CTRL_CAPA_BIT];
						st_next.capb = writedata[CTRL_CAPB_BIT];
					end
				end
				IDX_STATUS:
				begin
					// only a 0 clears, and only after the flag was read as 1
					if (byteenable[0])
					begin
						if (!writedata[ST_FLAGA_BIT] && st_reg.arm_a)
							st_next.flag_a = 1'b0;
						if (!writedata[ST_FLAGB_BIT] && st_reg.arm_b)
							st_next.flag_b = 1'b0;
						if (!writedata[ST_OVF_BIT] && st_reg.arm_ovf)
							st_next.ovf = 1'b0;
						if (!writedata[ST_UDF_BIT] && st_reg.arm_udf)
							st_next.udf = 1'b0;
						st_next.arm_a = 1'b0;
						st_next.arm_b = 1'b0;
						st_next.arm_ovf = 1'b0;
						st_next.arm_udf = 1'b0;
					end
				end
				IDX_COUNT:
				begin
					if (byteenable[0])
						cnt_new[7:0] = writedata[7:0];
					if (byteenable[1])
						cnt_new[15:8] = writedata[15:8];
				end
				IDX_GRA:
				begin
					if (byteenable[0])
						st_next.gra[7:0] = writedata[7:0];
					if (byteenable[1])
						st_next.gra[15:8] = writedata[15:8];
				end
				IDX_GRB:
				begin
					if (byteenable[0])
						st_next.grb[7:0] = writedata[7:0];
					if (byteenable[1])
						st_next.grb[15:8] = writedata[15:8];
				end
				default:
				begin
					st_next.rdata = st_next.rdata;
				end
			endcase
		end
		if (xfer_done_a && xfer_clear)
			st_next.flag_a = 1'b0;
		if (xfer_done_b && xfer_clear)
			st_next.flag_b = 1'b0;
		// a software counter write wins over a count edge in the same cycle
		if (!(wr_done && idx == IDX_COUNT))
		begin
			if (up_evt)
			begin
				cnt_new = st_reg.cnt + 16'h0001;
				st_next.dir = 1'b1;
				if (st_reg.cnt == COUNT_MAX)
					st_next.ovf = 1'b1;
			end
			else if (down_evt)
			begin
				cnt_new = st_reg.cnt - 16'h0001;
				st_next.dir = 1'b0;
				// underflow on wrap to all ones
				if (st_reg.cnt == COUNT_RESET)
					st_next.udf = 1'b1;
			end
			// compare match when the count reaches register A or B; sets win over clears
			if ((up_evt || down_evt) && !st_reg.capa && cnt_new == st_reg.gra)
				st_next.flag_a = 1'b1;
			if ((up_evt || down_evt) && !st_reg.capb && cnt_new == st_reg.grb)
				st_next.flag_b = 1'b1;
		end
		st_next.cnt = cnt_new;
		if (capture_a && st_reg.capa)
		begin
			st_next.gra = st_reg.cnt;
			st_next.flag_a = 1'b1;
		end
		if (capture_b && st_reg.capb)
		begin
			st_next.grb = st_reg.cnt;
			st_next.flag_b = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			st_reg <= '0;
			st_reg.cnt <= COUNT_RESET;
			// general registers reset to all ones
			st_reg.gra <= GR_RESET;
			st_reg.grb <= GR_RESET;
			st_reg.dir <= DIR_RESET;
			st_reg.mode <= TMC_MODE_NORMAL;
			st_reg.wait_hi <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign readdata = st_reg.rdata;
	assign waitrequest = st_reg.wait_hi;
	assign count_value = st_reg.cnt;
	assign count_up_dir = st_reg.dir;

	dir_up_a: assert property (@(posedge clock) disable iff (reset)
		up_evt && !(wr_done && idx == IDX_COUNT) |=> st_reg.dir == 1'b1)
		else $error("direction flag not 1 after up count");
	dir_down_a: assert property (@(posedge clock) disable iff (reset)
		down_evt && !(wr_done && idx == IDX_COUNT) |=> st_reg.dir == 1'b0)
		else $error("direction flag not 0 after down count");
	write_one_keeps_a: assert property (@(posedge clock) disable iff (reset)
		wr_done && idx == IDX_STATUS && writedata[ST_OVF_BIT] && st_reg.ovf |=> st_reg.ovf)
		else $error("writing 1 cleared overflow flag");
	xfer_keep_a: assert property (@(posedge clock) disable iff (reset)
		xfer_done_a && !xfer_clear && st_reg.flag_a && !(wr_done && idx == IDX_STATUS) |=> st_reg.flag_a)
		else $error("transfer cleared flag A without qualification");
	normal_up_only_a: assert property (@(posedge clock) disable iff (reset)
		st_reg.mode != TMC_MODE_PHASE && st_reg.mode != TMC_MODE_CASCADE |-> !down_evt)
		else $error("down count outside phase or cascade mode");
	gr_reset_a: assert property (@(posedge clock)
		reset |=> st_reg.gra == GR_RESET && st_reg.grb == GR_RESET && st_reg.cnt == COUNT_RESET)
		else $error("general registers or counter wrong after reset");
	count_step_a: assert property (@(posedge clock) disable iff (reset)
		up_evt && !(wr_done && idx == IDX_COUNT) |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
		else $error("counter did not step up by one");
	ovf_set_a: assert property (@(posedge clock) disable iff (reset)
		up_evt && st_reg.cnt == COUNT_MAX && !(wr_done && idx == IDX_COUNT) |=> st_reg.ovf && st_reg.cnt == 16'h0000)
		else $error("overflow flag not set on wrap");
	udf_set_a: assert property (@(posedge clock) disable iff (reset)
		down_evt && st_reg.cnt == COUNT_RESET && !(wr_done && idx == IDX_COUNT) |=> st_reg.udf && st_reg.cnt == COUNT_MAX)
		else $error("underflow flag not set on wrap");
	capture_a_a: assert property (@(posedge clock) disable iff (reset)
		capture_a && st_reg.capa |=> st_reg.flag_a && st_reg.gra == $past(st_reg.cnt))
		else $error("capture into register A failed");
	unarmed_clear_a: assert property (@(posedge clock) disable iff (reset)
		wr_done && idx == IDX_STATUS && !st_reg.arm_ovf && st_reg.ovf |=> st_reg.ovf)
		else $error("overflow flag cleared without prior read");
endmodule : tmc_channel_counter
`default_nettype wire

// File: hdl/tmc_pkg.sv
/*
 Constants, register map and state type for the channel two counter block.
 Assumes a 32-bit Avalon-MM master with byte addresses and one clock domain.
*/
// Behaviour
// - direction flag reads 0 while counting down, 1 while counting up.
// - software can only clear status flags by writing 0; writing 1 leaves them.
// - transfer controller clears its flag only with disable-select 0 and count nonzero.
// - counter counts both ways only in phase or cascaded overflow/underflow mode.
// - in normal mode the counter only increments; the unused mode 3 does not count at all.
// - two 16-bit general registers after the counter, reset to all ones.
// - overflow flag sets when counting up wraps all ones to zero.
// - underflow flag sets when counting down wraps zero to all ones.
// - flag A sets on compare match with register A or on capture into it.
`default_nettype none
package tmc_pkg;
	localparam int ADDR_W = 18;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [15:0] IDX_CTRL = 16'hFFF0;
	localparam logic [15:0] IDX_STATUS = 16'hFFF5;
	localparam logic [15:0] IDX_COUNT = 16'hFFF6;
	localparam logic [15:0] IDX_GRA = 16'hFFF8;
	localparam logic [15:0] IDX_GRB = 16'hFFFA;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_CAPA_BIT = 3;
	localparam int CTRL_CAPB_BIT = 4;
	// status register fields
	localparam int ST_FLAGA_BIT = 0;
	localparam int ST_FLAGB_BIT = 1;
	localparam int ST_OVF_BIT = 4;
	localparam int ST_UDF_BIT = 5;
	localparam int ST_RSV_BIT = 6;
	localparam int ST_DIR_BIT = 7;
	// reset values and counter maximum
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] GR_RESET = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic DIR_RESET = 1'h1;

	typedef enum logic [1:0] {
		TMC_MODE_NORMAL = 2'b00,
		TMC_MODE_PHASE = 2'b01,
		TMC_MODE_CASCADE = 2'b10
	} tmc_mode_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] gra;
		logic [15:0] grb;
		logic en;
		tmc_mode_t mode;
		logic capa;
		logic capb;
		logic flag_a;
		logic flag_b;
		logic ovf;
		logic udf;
		logic dir;
		logic arm_a;
		logic arm_b;
		logic arm_ovf;
		logic arm_udf;
		logic ph_a;
		logic ph_b;
		logic wait_hi;
		logic [31:0] rdata;
	} tmc_state_t;
endpackage : tmc_pkg
`default_nettype wire

// File: verif/tmc_channel_counter_bench.sv
/*
 Self-checking bench for the channel two counter: register bus, count modes, flags.
 Assumes tmc_pkg and tmc_channel_counter from hdl/ are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_channel_counter_bench
	import tmc_pkg::*;
;
	logic clock, reset, read, write, waitrequest, count_up_dir;
	logic phase_a, phase_b, dsel, nzero;
	logic [ADDR_W-1:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, rd;
	logic [15:0] count_value;
	// event pulses: tick, cascade up, cascade down, capture a, transfer a, capture b, transfer b
	logic [6:0] ev;
	int mismatches, n_tests, cycles;

	tmc_channel_counter DUT (
		.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .count_tick(ev[0]), .phase_a(phase_a), .phase_b(phase_b),
		.cascade_overflow(ev[1]), .cascade_underflow(ev[2]), .capture_a(ev[3]), .capture_b(ev[5]),
		.xfer_done_a(ev[4]), .xfer_done_b(ev[6]), .xfer_disable_select(dsel),
		.xfer_count_nonzero(nzero), .count_value(count_value), .count_up_dir(count_up_dir)
	);

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// the whole sequence needs well under a thousand cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask, input string what);
		n_tests++;
		if (((got ^ exp) & mask) !== 32'h0000_0000)
		begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp

	// one Avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
		int n;
		@(posedge clock);
		address <= {idx, 2'b00};
		writedata <= {16'h0000, wd};
		read <= ~wr;
		write <= wr;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// a hung slave is caught by the cycle ceiling; the answer itself comes after one wait cycle
		cmp(n, 32'h0000_0002, 32'hFFFF_FFFF, "bus answer latency");
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d);
	endtask : wr

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] mask, input string what);
		bus(1'b0, idx, 16'h0000);
		cmp(rd, exp, mask, what);
	endtask : rdchk

	task automatic pulse(input int b);
		@(posedge clock);
		ev[b] <= 1'b1;
		@(posedge clock);
		ev <= 7'h00;
		repeat (2) @(posedge clock);
	endtask : pulse

	task automatic outs(input logic [15:0] c, input logic d, input string what);
		cmp({15'h0000, count_up_dir, count_value}, {15'h0000, d, c}, 32'h0001_FFFF, what);
	endtask : outs

	task automatic t_reset;
		rdchk(IDX_COUNT, 32'h0000_0000, 32'hFFFF_FFFF, "count after reset");
		rdchk(IDX_GRA, 32'h0000_FFFF, 32'hFFFF_FFFF, "register a after reset");
		rdchk(IDX_GRB, 32'h0000_FFFF, 32'hFFFF_FFFF, "register b after reset");
		rdchk(IDX_STATUS, 32'h0000_00C0, 32'hFFFF_FFFF, "status after reset");
		rdchk(16'hFFF1, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped read");
		wr(IDX_GRB, 16'hA5C3);
		rdchk(IDX_GRB, 32'h0000_A5C3, 32'hFFFF_FFFF, "register b write");
		outs(16'h0000, 1'b1, "outputs after reset");
		$display("test reset done");
	endtask : t_reset

	task automatic t_overflow;
		wr(IDX_COUNT, 16'hFFFF);
		wr(IDX_CTRL, 16'h0001);
		pulse(0);
		outs(16'h0000, 1'b1, "wrap upward");
		// a zero write without a prior read of the flag must not clear it
		wr(IDX_STATUS, 16'h0000);
		rdchk(IDX_STATUS, 32'h0000_00D0, 32'hFFFF_FFFF, "overflow set");
		wr(IDX_STATUS, 16'h00FF);
		wr(IDX_STATUS, 16'h0000);
		rdchk(IDX_STATUS, 32'h0000_00D0, 32'hFFFF_FFFF, "overflow kept");
		wr(IDX_STATUS, 16'h0000);
		rdchk(IDX_STATUS, 32'h0000_00C0, 32'hFFFF_FFFF, "overflow cleared");
		$display("test overflow done");
	endtask : t_overflow

	task automatic t_compare;
		wr(IDX_GRA, 16'h0005);
		wr(IDX_COUNT, 16'h0004);
		pulse(0);
		rdchk(IDX_STATUS, 32'h0000_00C1, 32'hFFFF_FFFF, "compare match a");
		dsel <= 1'b1;
		nzero <= 1'b1;
		pulse(4);
		rdchk(IDX_STATUS, 32'h0000_00C1, 32'hFFFF_FFFF, "transfer with disable");
		dsel <= 1'b0;
		nzero <= 1'b0;
		pulse(4);
		rdchk(IDX_STATUS, 32'h0000_00C1, 32'hFFFF_FFFF, "transfer count zero");
		nzero <= 1'b1;
		pulse(4);
		rdchk(IDX_STATUS, 32'h0000_00C0, 32'hFFFF_FFFF, "transfer clears");
		wr(IDX_CTRL, 16'h0009);
		wr(IDX_COUNT, 16'h1234);
		pulse(3);
		rdchk(IDX_GRA, 32'h0000_1234, 32'hFFFF_FFFF, "capture value");
		rdchk(IDX_STATUS, 32'h0000_0001, 32'h0000_0001, "capture flag");
		// flag b: capture sets it, its own transfer clears it and leaves flag a alone
		wr(IDX_CTRL, 16'h0019);
		pulse(5);
		rdchk(IDX_STATUS, 32'h0000_0003, 32'h0000_0003, "both flags set");
		pulse(6);
		rdchk(IDX_STATUS, 32'h0000_0001, 32'h0000_0003, "transfer clears b only");
		wr(IDX_STATUS, 16'h0000);
		rdchk(IDX_STATUS, 32'h0000_0000, 32'h0000_0003, "flag a cleared after read");
		$display("test compare done");
	endtask : t_compare

	task automatic t_cascade;
		wr(IDX_CTRL, 16'h0005);
		wr(IDX_COUNT, 16'h0000);
		pulse(2);
		outs(16'hFFFF, 1'b0, "cascade down wrap");
		rdchk(IDX_STATUS, 32'h0000_0060, 32'h0000_00E0, "underflow set");
		pulse(1);
		outs(16'h0000, 1'b1, "cascade up wrap");
		rdchk(IDX_STATUS, 32'h0000_00D0, 32'h0000_00D0, "cascade overflow");
		$display("test cascade done");
	endtask : t_cascade

	task automatic t_phase;
		wr(IDX_CTRL, 16'h0003);
		wr(IDX_COUNT, 16'h0010);
		phase_a <= 1'b1;
		repeat (3) @(posedge clock);
		outs(16'h0011, 1'b1, "phase step up");
		phase_a <= 1'b0;
		repeat (3) @(posedge clock);
		outs(16'h0010, 1'b0, "phase step down");
		// normal mode ignores the quadrature inputs and only counts up
		wr(IDX_CTRL, 16'h0001);
		phase_b <= 1'b1;
		repeat (3) @(posedge clock);
		outs(16'h0010, 1'b0, "phase ignored");
		pulse(0);
		outs(16'h0011, 1'b1, "normal counts up");
		$display("test phase done");
	endtask : t_phase

	initial
	begin
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		byteenable = 4'hF;
		writedata = 32'h0000_0000;
		ev = 7'h00;
		phase_a = 1'b0;
		phase_b = 1'b0;
		dsel = 1'b0;
		nzero = 1'b0;
		mismatches = 0;
		n_tests = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_overflow();
		t_compare();
		t_cascade();
		t_phase();
		final_report();
	end
endmodule : tmc_channel_counter_bench
`default_nettype wire
